// ===== dv/dmd_checker.sv
/*
  Checker of the memory-map decoder: latencies, decode targets, paging, vectors.
  Assumes binding to dmd_decoder on its single clock clk.
*/
`timescale 1ns/1ns
module dmd_checker (
  input wire logic               clk,              // Core clock
  input wire logic               rst_n,            // Hardware reset
  input wire logic               rom_enable_strap, // Strap pin
  input wire logic               rom_protect_pin,  // Protect pin
  input wire dmd_pkg::dmd_areq_t a_req,            // Port A request
  input wire dmd_pkg::dmd_breq_t b_req,            // Port B request
  input wire logic               vec_req,          // Vector taken
  input wire logic [4:0]         vec_num,          // Vector number
  input wire logic [15:0]        rom_rdata,        // ROM data
  input wire dmd_pkg::dmd_rsp_t  a_rsp,            // Port A answer
  input wire dmd_pkg::dmd_rsp_t  b_rsp,            // Port B answer
  input wire dmd_pkg::dmd_ext_t  ext_bus,          // External cycle
  input wire logic               rom_cs,           // ROM select
  input wire logic [13:0]        rom_addr,         // ROM address
  input wire dmd_pkg::dmd_rgn_t  rom_region,       // ROM region
  input wire logic [22:0]        prog_addr,        // Program address
  input wire dmd_pkg::dmd_vec_t  pc_load           // PC load
);
  logic live_q;

  // Requests in the init cycle get no answer, so gate on it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) live_q <= 1'b0;
    else        live_q <= 1'b1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_init; !live_q ##1 live_q; endsequence
  sequence s_fetch; live_q && a_req.valid && a_req.prog; endsequence
  sequence s_bdata; live_q && b_req.valid; endsequence

  property p_rst_vec; s_init |-> pc_load.valid && pc_load.addr == 16'hff80; endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("reset vector wrong");
  property p_prog_addr; s_fetch |=> prog_addr[15:0] == $past(a_req.addr); endproperty
  a_prog_addr: assert property (p_prog_addr) else $error("program address wrong");
  property p_a_lat; live_q && a_req.valid |-> ##2 a_rsp.valid; endproperty
  a_a_lat: assert property (p_a_lat) else $error("port A answer missing");
  property p_b_lat; s_bdata |-> ##2 b_rsp.valid; endproperty
  a_b_lat: assert property (p_b_lat) else $error("port B answer missing");
  property p_data_ext; s_bdata ##0 b_req.addr[15] |-> ##2 b_rsp.ext && !b_rsp.denied; endproperty
  a_data_ext: assert property (p_data_ext) else $error("high data address not external");
  property p_data_rom; live_q && a_req.valid && !a_req.prog |=> !rom_cs; endproperty
  a_data_rom: assert property (p_data_rom) else $error("ROM selected from data space");
  property p_rom_data; rom_cs |=> a_rsp.valid && a_rsp.data == $past(rom_rdata); endproperty
  a_rom_data: assert property (p_rom_data) else $error("ROM data not returned");
  property p_rom_addr; rom_cs |-> prog_addr[15:14] == 2'b11 && rom_addr == prog_addr[13:0]; endproperty
  a_rom_addr: assert property (p_rom_addr) else $error("ROM address wrong");
  property p_ext_page; ext_bus.req && ext_bus.prog |-> ext_bus.addr == prog_addr; endproperty
  a_ext_page: assert property (p_ext_page) else $error("external page wrong");
  property p_vec; live_q && vec_req |=> pc_load.valid && pc_load.addr[6:0] == {$past(vec_num), 2'b00}; endproperty
  a_vec: assert property (p_vec) else $error("vector entry wrong");
endmodule

bind dmd_decoder dmd_checker dmd_checker_inst (
  .clk(clk), .rst_n(rst_n), .rom_enable_strap(rom_enable_strap), .rom_protect_pin(rom_protect_pin),
  .a_req(a_req), .b_req(b_req), .vec_req(vec_req), .vec_num(vec_num), .rom_rdata(rom_rdata),
  .a_rsp(a_rsp), .b_rsp(b_rsp), .ext_bus(ext_bus), .rom_cs(rom_cs), .rom_addr(rom_addr),
  .rom_region(rom_region), .prog_addr(prog_addr), .pc_load(pc_load)
);

// ===== dv/dmd_decoder_bench.sv
/*
  Self-checking bench of the memory-map decoder with a mask ROM model.
  Assumes dmd_pkg compiled first and the checker bound to the decoder.
*/
`timescale 1ns/1ns
module dmd_decoder_bench;
  logic clk, rst_n, strap, prot, vreq, cs;
  logic [4:0] vnum;
  logic [13:0] radr;
  logic [15:0] rdata;
  logic [22:0] padr, spa;
  dmd_pkg::dmd_areq_t a;
  dmd_pkg::dmd_breq_t b;
  dmd_pkg::dmd_rsp_t ar, br, ra, rb;
  dmd_pkg::dmd_ext_t eb, se;
  dmd_pkg::dmd_rgn_t rgn, srg;
  dmd_pkg::dmd_vec_t pcl;
  logic scs;
  int err_total, checks;
  logic [15:0] rom_ad [8] = '{16'hc000, 16'hd4ff, 16'hd500, 16'hf800, 16'hfbff, 16'hff00, 16'hff7f, 16'hff80};
  dmd_pkg::dmd_rgn_t rom_rg [8] = '{dmd_pkg::RGN_CODEC, dmd_pkg::RGN_CODEC, dmd_pkg::RGN_MISC, dmd_pkg::RGN_BOOT,
    dmd_pkg::RGN_BOOT, dmd_pkg::RGN_TEST, dmd_pkg::RGN_TEST, dmd_pkg::RGN_VECT};
  logic [15:0] ram_ad [5] = '{16'h0080, 16'h1fff, 16'h2000, 16'h4000, 16'h7fff};

  dmd_decoder dmd_decoder_inst (.clk(clk), .rst_n(rst_n), .rom_enable_strap(strap), .rom_protect_pin(prot),
    .a_req(a), .b_req(b), .vec_req(vreq), .vec_num(vnum), .rom_rdata(rdata), .a_rsp(ar), .b_rsp(br),
    .ext_bus(eb), .rom_cs(cs), .rom_addr(radr), .rom_region(rgn), .prog_addr(padr), .pc_load(pcl));
  dmd_rom_model dmd_rom_model_inst (.clk(clk), .rom_cs(cs), .rom_addr(radr), .rom_rdata(rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic close_out;
    $display("Counts: checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic dmd_pkg::dmd_areq_t fa(input logic [15:0] ad, input logic eo = 1'b0, input logic pg = 1'b1);
    return {1'b1, pg, eo, ad};
  endfunction

  function automatic dmd_pkg::dmd_breq_t fb(input logic w, h, input logic [15:0] ad, wd);
    return {1'b1, w, h, ad, wd};
  endfunction

  // Placement shows after the taking edge, answer one edge later; one-cycle outputs snapped there
  task automatic acc(input dmd_pkg::dmd_areq_t ta, input dmd_pkg::dmd_breq_t tb);
    @(posedge clk);
    a <= ta;
    b <= tb;
    @(posedge clk);
    a.valid <= 1'b0;
    b.valid <= 1'b0;
    #1 se = eb;
    scs = cs;
    srg = rgn;
    spa = padr;
    @(posedge clk);
    #1 ra = ar;
    rb = br;
  endtask

  task automatic bwr(input logic [15:0] ad, wd); acc('0, fb(1'b1, 1'b0, ad, wd)); endtask
  task automatic brd(input logic [15:0] ad); acc('0, fb(1'b0, 1'b0, ad, 16'h0000)); endtask
  task automatic fetch(input logic [15:0] ad); acc(fa(ad), '0); endtask

  task automatic vec(input logic [4:0] n, input logic [15:0] exp);
    @(posedge clk);
    vreq <= 1'b1;
    vnum <= n;
    @(posedge clk);
    vreq <= 1'b0;
    #1 chk(pcl.valid, 1'b1);
    chk(pcl.addr, exp);
  endtask

  task automatic t_reset;
    chk(rgn, dmd_pkg::RGN_NONE);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk(pcl.valid, 1'b1);
    chk(pcl.addr, 16'hff80);
    brd(16'h001e);
    chk(rb.data, 16'h0000);
    brd(16'h0018);
    chk(rb.data, 16'hff80);
    $display("t_reset done");
  endtask

  task automatic t_page;
    bwr(16'h001e, 16'hff05);
    brd(16'h001e);
    chk(rb.data, 16'h0005);
    fetch(16'h1234);
    chk(ra.ext, 1'b1);
    chk(se.prog, 1'b1);
    chk(se.addr, {7'h05, 16'h1234});
    chk(spa, {7'h05, 16'h1234});
    bwr(16'h001e, 16'h007f);
    fetch(16'hffff);
    chk(spa, 23'h7fffff);
    chk(scs, 1'b1);
    bwr(16'h001e, 16'h0000);
    $display("t_page done");
  endtask

  task automatic t_data;
    foreach (ram_ad[i]) bwr(ram_ad[i], ram_ad[i] ^ 16'h5aa5);
    foreach (ram_ad[i]) begin
      brd(ram_ad[i]);
      chk(rb.ext, 1'b0);
      chk(rb.data, ram_ad[i] ^ 16'h5aa5);
    end
    brd(16'h8000);
    chk(rb.ext, 1'b1);
    chk(se.addr[15:0], 16'h8000);
    brd(16'hc000);
    chk(scs, 1'b0);
    chk(se.req, 1'b1);
    bwr(16'h9000, 16'h3c3c);
    chk(rb.ext, 1'b1);
    chk(se.write, 1'b1);
    chk(se.prog, 1'b0);
    chk(se.wdata, 16'h3c3c);
    chk(se.addr, 23'h009000);
    acc(fa(16'hc000, 1'b0, 1'b0), '0);
    chk(scs, 1'b0);
    chk(ra.ext, 1'b1);
    $display("t_data done");
  endtask

  task automatic t_rom;
    foreach (rom_ad[i]) begin
      fetch(rom_ad[i]);
      chk(scs, 1'b1);
      chk(radr, rom_ad[i][13:0]);
      chk(srg, rom_rg[i]);
      chk(ra.data, rom_ad[i][15:7] == 9'h1fe ? 16'h0000 : {2'b10, rom_ad[i][13:0]});
    end
    $display("t_rom done");
  endtask

  task automatic t_ram_overlay;
    bwr(16'h0018, 16'hffa0);
    bwr(16'h2000, 16'h1357);
    fetch(16'h2000);
    chk(ra.ext, 1'b0);
    chk(ra.data, 16'h1357);
    fetch(16'h0050);
    chk(ra.ext, 1'b1);
    acc(fa(16'h2000), fb(1'b1, 1'b0, 16'h2000, 16'h2468));
    chk(ra.data, 16'h1357);
    brd(16'h2000);
    chk(rb.data, 16'h2468);
    bwr(16'h0018, 16'hffc0);
    fetch(16'hc000);
    chk(scs, 1'b0);
    bwr(16'h0018, 16'hff80);
    $display("t_ram_overlay done");
  endtask

  task automatic t_vec;
    vec(5'd0, 16'hff80);
    vec(5'd31, 16'hfffc);
    bwr(16'h0018, 16'h0100);
    vec(5'd3, 16'h010c);
    bwr(16'h0018, 16'hff80);
    $display("t_vec done");
  endtask

  task automatic t_prot;
    @(posedge clk) prot <= 1'b1;
    repeat (3) @(posedge clk);
    acc('0, fb(1'b0, 1'b1, 16'h2000, 16'h0000));
    chk(rb.denied, 1'b1);
    chk(rb.data, 16'h0000);
    acc('0, fb(1'b0, 1'b1, 16'h4000, 16'h0000));
    chk(rb.data, 16'h4000 ^ 16'h5aa5);
    acc('0, fb(1'b1, 1'b1, 16'h2000, 16'h0f0f));
    chk(rb.denied, 1'b0);
    acc(fa(16'hff80, 1'b1), '0);
    chk(ra.denied, 1'b1);
    chk(scs, 1'b0);
    @(posedge clk) prot <= 1'b0;
    repeat (3) @(posedge clk);
    brd(16'h2000);
    chk(rb.data, 16'h0f0f);
    $display("t_prot done");
  endtask

  // Second reset with the strap high: ROM must drop out, page select must clear
  task automatic t_strap;
    bwr(16'h001e, 16'h0033);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= 1'b1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk(pcl.valid, 1'b1);
    chk(pcl.addr, 16'hff80);
    brd(16'h001e);
    chk(rb.data, 16'h0000);
    brd(16'h0018);
    chk(rb.data, 16'hffc0);
    fetch(16'hff80);
    chk(scs, 1'b0);
    chk(ra.ext, 1'b1);
    chk(se.addr, 23'h00ff80);
    $display("t_strap done");
  endtask

  initial begin
    rst_n = 1'b0;
    strap = 1'b0;
    prot = 1'b0;
    vreq = 1'b0;
    vnum = 5'd0;
    a = '0;
    b = '0;
    repeat (6) @(posedge clk);
    t_reset();
    t_page();
    t_data();
    t_rom();
    t_ram_overlay();
    t_vec();
    t_prot();
    t_strap();
    close_out();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("Error at %0t: run timed out", $time);
    close_out();
  end
endmodule

// ===== dv/dmd_rom_model.sv
/*
  Mask ROM model answering the decoder's ROM select asynchronously.
  Assumes the decoder samples data one cycle after raising the select.
*/
`timescale 1ns/1ns
module dmd_rom_model (
  input  wire logic        clk,       // Core clock
  input  wire logic        rom_cs,    // ROM select
  input  wire logic [13:0] rom_addr,  // ROM word address
  output logic [15:0]      rom_rdata  // ROM data
);
  logic [15:0] noise_q = 16'h0001;

  // Unselected ROM shows a moving pattern, not stale data
  always_ff @(posedge clk) noise_q <= noise_q + 16'h3b1d;

  // Factory-test words left blank; other words tagged by address
  assign rom_rdata = !rom_cs ? noise_q : (rom_addr[13:7] == 7'h7e) ? 16'h0000 : {2'b10, rom_addr};
endmodule

// ===== inc/dmd_consts.svh
/*
  Address map, field positions and reset values of the memory-map decoder.
  Assumes inclusion by bare name from the package and the decoder module.
*/
`ifndef DMD_CONSTS_SVH
`define DMD_CONSTS_SVH

// Data space: 64K words of 16 bits
`define DMD_ADDR_BITS      16
`define DMD_PAGE_BITS      7

// Memory-mapped registers in data page 0
`define DMD_PAGE_SEL_ADDR  16'h001e
`define DMD_MODE_ADDR      16'h0018
`define DMD_PAGE_SEL_RST   7'h00

// Mode register fields
`define DMD_VPTR_MSB       15
`define DMD_VPTR_LSB       7
`define DMD_ROM_DIS_BIT    6
`define DMD_RAM_OVERLAY_BIT       5
`define DMD_VPTR_RST       9'h1ff
`define DMD_RAM_OVERLAY_RST       1'b0

// Dual-access RAM
`define DMD_RAM_LO         16'h0080
`define DMD_RAM_BLOCKS     4
`define DMD_BLOCK_WORDS    8192
`define DMD_HOST_LO        16'h4000
`define DMD_HOST_HI        16'h5fff

// Mask ROM, program space only
`define DMD_ROM_LO         16'hc000
`define DMD_ROM_AW         14
`define DMD_CODEC_LO       16'hc000
`define DMD_CODEC_HI       16'hd4ff
`define DMD_BOOT_LO        16'hf800
`define DMD_BOOT_HI        16'hfbff
`define DMD_TEST_LO        16'hff00
`define DMD_TEST_HI        16'hff7f
`define DMD_VECT_LO        16'hff80

// Vector table: four words per entry
`define DMD_VEC_NUM_BITS   5
`define DMD_VEC_SHIFT      2

`endif

// ===== inc/dmd_pkg.sv
/*
  Types of the memory-map decoder: targets, ROM regions, request and answer carriers.
  Assumes dmd_consts.svh on the include path.
*/
`include "dmd_consts.svh"

package dmd_pkg;

  typedef enum logic [2:0] {
    TGT_NONE = 3'b000,
    TGT_RAM  = 3'b001,
    TGT_ROM  = 3'b010,
    TGT_MMR  = 3'b011,
    TGT_EXT  = 3'b100,
    TGT_DENY = 3'b101
  } dmd_tgt_t;

  typedef enum logic [2:0] {
    RGN_NONE  = 3'b000,
    RGN_CODEC = 3'b001,
    RGN_BOOT  = 3'b010,
    RGN_TEST  = 3'b011,
    RGN_VECT  = 3'b100,
    RGN_MISC  = 3'b101
  } dmd_rgn_t;

  typedef struct packed {
    logic        valid;
    logic        prog;
    logic        ext_org;
    logic [15:0] addr;
  } dmd_areq_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        host;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dmd_breq_t;

  typedef struct packed {
    logic        valid;
    logic        ext;
    logic        denied;
    logic [15:0] data;
  } dmd_rsp_t;

  typedef struct packed {
    logic        req;
    logic        prog;
    logic        write;
    logic [22:0] addr;
    logic [15:0] wdata;
  } dmd_ext_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } dmd_vec_t;

endpackage

// ===== rtl/dmd_decoder.sv
/*
  Memory-map decoder: data/program decode, dual-access RAM, paging, vectors.
  Assumes core ports on clk; straps and protect option come from pins.
*/
`timescale 1ns/1ns
`include "dmd_consts.svh"

module dmd_decoder #(
  parameter int RAM_BLOCKS  = `DMD_RAM_BLOCKS,
  parameter int BLOCK_WORDS = `DMD_BLOCK_WORDS
) (
  input  wire logic              clk,              // 100 MHz core clock
  input  wire logic              rst_n,            // Hardware reset
  input  wire logic              rom_enable_strap, // Pin, low enables ROM
  input  wire logic              rom_protect_pin,  // Pin, memory protect option
  input  wire dmd_pkg::dmd_areq_t a_req,           // Read port, program or data
  input  wire dmd_pkg::dmd_breq_t b_req,           // Data read/write port
  input  wire logic              vec_req,          // Interrupt or trap taken
  input  wire logic [4:0]        vec_num,          // Vector entry number
  input  wire logic [15:0]       rom_rdata,        // Async mask ROM data
  output dmd_pkg::dmd_rsp_t      a_rsp,            // Port A answer
  output dmd_pkg::dmd_rsp_t      b_rsp,            // Port B answer
  output dmd_pkg::dmd_ext_t      ext_bus,          // External bus cycle
  output logic                   rom_cs,           // Mask ROM select
  output logic [13:0]            rom_addr,         // Mask ROM word address
  output dmd_pkg::dmd_rgn_t      rom_region,       // ROM region of last ROM fetch
  output logic [22:0]            prog_addr,        // Last program address
  output dmd_pkg::dmd_vec_t      pc_load           // Program counter load
);

  localparam int AW   = $clog2(BLOCK_WORDS);
  localparam int BSEL = (RAM_BLOCKS > 1) ? $clog2(RAM_BLOCKS) : 1;
  localparam logic [15:0] RAM_HI = 16'((RAM_BLOCKS * BLOCK_WORDS) - 1);

  // Blocks must fit within 0000h-7FFFh on power-of-two bounds, at least 256 words each
  if ((1 << AW) != BLOCK_WORDS || (1 << BSEL) != RAM_BLOCKS ||
      RAM_BLOCKS * BLOCK_WORDS > 32768 || BLOCK_WORDS < 256) begin : g_chk
    $error("dmd_decoder: RAM geometry not supported");
  end

  // Pin synchronisers; no reset so the strap is valid at the first edge
  logic strap_s1_q, strap_s2_q;
  logic prot_s1_q, prot_s2_q;

  always_ff @(posedge clk) begin
    strap_s1_q <= rom_enable_strap;
    strap_s2_q <= strap_s1_q;
    prot_s1_q  <= rom_protect_pin;
    prot_s2_q  <= prot_s1_q;
  end

  // Control state
  logic                  init_q;
  logic [6:0]            page_q;
  logic [8:0]            vptr_q;
  logic                  rom_dis_q;
  logic                  ram_overlay_q;

  function automatic dmd_pkg::dmd_tgt_t dmd_decode(
    input logic [15:0] addr,
    input logic        prog,
    input logic        ram_overlay,
    input logic        rom_dis
  );
    dmd_pkg::dmd_tgt_t t;
    t = dmd_pkg::TGT_EXT;
    if (prog) begin
      if (!rom_dis && addr >= `DMD_ROM_LO) begin
        t = dmd_pkg::TGT_ROM;
      end else if (ram_overlay && addr >= `DMD_RAM_LO && addr <= RAM_HI) begin
        t = dmd_pkg::TGT_RAM;
      end
    end else begin
      if (addr < `DMD_RAM_LO) begin
        t = dmd_pkg::TGT_MMR;
      end else if (addr <= RAM_HI) begin
        t = dmd_pkg::TGT_RAM;
      end
    end
    return t;
  endfunction

  function automatic dmd_pkg::dmd_rgn_t dmd_region(input logic [15:0] addr);
    dmd_pkg::dmd_rgn_t r;
    r = dmd_pkg::RGN_MISC;
    if (addr >= `DMD_CODEC_LO && addr <= `DMD_CODEC_HI) begin
      r = dmd_pkg::RGN_CODEC;
    end else if (addr >= `DMD_BOOT_LO && addr <= `DMD_BOOT_HI) begin
      r = dmd_pkg::RGN_BOOT;
    end else if (addr >= `DMD_TEST_LO && addr <= `DMD_TEST_HI) begin
      r = dmd_pkg::RGN_TEST;
    end else if (addr >= `DMD_VECT_LO) begin
      r = dmd_pkg::RGN_VECT;
    end
    return r;
  endfunction

  function automatic logic [15:0] dmd_mmr(
    input logic [15:0] addr,
    input logic [6:0]  page,
    input logic [8:0]  vptr,
    input logic        rom_dis,
    input logic        ram_overlay
  );
    logic [15:0] v;
    v = 16'h0000;
    if (addr == `DMD_PAGE_SEL_ADDR) begin
      v = {9'h000, page};
    end else if (addr == `DMD_MODE_ADDR) begin
      v = {vptr, rom_dis, ram_overlay, 5'h00};
    end
    return v;
  endfunction

  // Decode of both ports, protection applied after the map
  dmd_pkg::dmd_tgt_t a_tgt, b_tgt;
  logic              a_onchip, b_onchip, b_host_ok;

  always_comb begin
    a_tgt = dmd_pkg::TGT_NONE;
    b_tgt = dmd_pkg::TGT_NONE;
    a_onchip = 1'b0;
    b_onchip = 1'b0;
    b_host_ok = (b_req.addr >= `DMD_HOST_LO) && (b_req.addr <= `DMD_HOST_HI);
    if (a_req.valid && !init_q) begin
      a_tgt = dmd_decode(a_req.addr, a_req.prog, ram_overlay_q, rom_dis_q);
      a_onchip = (a_tgt != dmd_pkg::TGT_EXT);
      if (prot_s2_q && a_req.ext_org && a_onchip) begin
        a_tgt = dmd_pkg::TGT_DENY;
      end
    end
    if (b_req.valid && !init_q) begin
      b_tgt = dmd_decode(b_req.addr, 1'b0, ram_overlay_q, rom_dis_q);
      b_onchip = (b_tgt != dmd_pkg::TGT_EXT);
      if (prot_s2_q && b_req.host && !b_req.write && b_onchip && !b_host_ok) begin
        b_tgt = dmd_pkg::TGT_DENY;
      end
    end
  end

  // RAM block strobes; block index is the address above the block offset
  logic [RAM_BLOCKS-1:0] a_rd_en, b_rd_en, b_wr_en;
  logic [BSEL-1:0]       a_blk, b_blk;

  always_comb begin
    a_blk = a_req.addr[AW +: BSEL];
    b_blk = b_req.addr[AW +: BSEL];
    a_rd_en = '0;
    b_rd_en = '0;
    b_wr_en = '0;
    if (a_tgt == dmd_pkg::TGT_RAM) begin
      a_rd_en[a_blk] = 1'b1;
    end
    if (b_tgt == dmd_pkg::TGT_RAM) begin
      if (b_req.write) begin
        b_wr_en[b_blk] = 1'b1;
      end else begin
        b_rd_en[b_blk] = 1'b1;
      end
    end
  end

  // One array per block: port A reads, port B reads or writes
  logic [15:0] a_word [RAM_BLOCKS];
  logic [15:0] b_word [RAM_BLOCKS];

  for (genvar g = 0; g < RAM_BLOCKS; g++) begin : g_blk
    logic [15:0] mem [BLOCK_WORDS];

    always_ff @(posedge clk) begin
      if (b_wr_en[g]) begin
        mem[b_req.addr[AW-1:0]] <= b_req.wdata;
      end
      if (b_rd_en[g]) begin
        b_word[g] <= mem[b_req.addr[AW-1:0]];
      end
      if (a_rd_en[g]) begin
        a_word[g] <= mem[a_req.addr[AW-1:0]];
      end
    end
  end

  // Strap capture in the first cycle after reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_q <= 1'b1;
    end else begin
      init_q <= 1'b0;
    end
  end

  // Register writes over port B; strap capture has priority
  logic mmr_wr;
  assign mmr_wr = (b_tgt == dmd_pkg::TGT_MMR) && b_req.write;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_q <= `DMD_PAGE_SEL_RST;
    end else if (mmr_wr && b_req.addr == `DMD_PAGE_SEL_ADDR) begin
      page_q <= b_req.wdata[6:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vptr_q    <= `DMD_VPTR_RST;
      rom_dis_q <= 1'b1;
      ram_overlay_q    <= `DMD_RAM_OVERLAY_RST;
    end else if (init_q) begin
      rom_dis_q <= strap_s2_q;
    end else if (mmr_wr && b_req.addr == `DMD_MODE_ADDR) begin
      vptr_q    <= b_req.wdata[`DMD_VPTR_MSB:`DMD_VPTR_LSB];
      rom_dis_q <= b_req.wdata[`DMD_ROM_DIS_BIT];
      ram_overlay_q    <= b_req.wdata[`DMD_RAM_OVERLAY_BIT];
    end
  end

  // Access stage: targets, block, register snapshot
  dmd_pkg::dmd_tgt_t a_tgt_q, b_tgt_q;
  logic [BSEL-1:0]   a_blk_q, b_blk_q;
  logic [15:0]       a_mmr_q, b_mmr_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_tgt_q <= dmd_pkg::TGT_NONE;
      b_tgt_q <= dmd_pkg::TGT_NONE;
      a_blk_q <= '0;
      b_blk_q <= '0;
      a_mmr_q <= 16'h0000;
      b_mmr_q <= 16'h0000;
    end else begin
      a_tgt_q <= a_tgt;
      b_tgt_q <= b_tgt;
      a_blk_q <= a_blk;
      b_blk_q <= b_blk;
      a_mmr_q <= dmd_mmr(a_req.addr, page_q, vptr_q, rom_dis_q, ram_overlay_q);
      b_mmr_q <= dmd_mmr(b_req.addr, page_q, vptr_q, rom_dis_q, ram_overlay_q);
    end
  end

  // Mask ROM address and program address out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rom_cs     <= 1'b0;
      rom_addr   <= '0;
      rom_region <= dmd_pkg::RGN_NONE;
      prog_addr  <= 23'h000000;
    end else begin
      rom_cs <= (a_tgt == dmd_pkg::TGT_ROM);
      if (a_tgt == dmd_pkg::TGT_ROM) begin
        rom_addr   <= a_req.addr[`DMD_ROM_AW-1:0];
        rom_region <= dmd_region(a_req.addr);
      end
      if (a_req.valid && a_req.prog && !init_q) begin
        prog_addr <= {page_q, a_req.addr};
      end
    end
  end

  // External bus cycle; port A access, program fetch or data read, wins; port B's cycle is not issued but still gets an ext answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_bus <= '0;
    end else begin
      ext_bus.req <= 1'b0;
      if (a_tgt == dmd_pkg::TGT_EXT) begin
        ext_bus.req   <= 1'b1;
        ext_bus.prog  <= a_req.prog;
        ext_bus.write <= 1'b0;
        ext_bus.addr  <= a_req.prog ? {page_q, a_req.addr} : {7'h00, a_req.addr};
        ext_bus.wdata <= 16'h0000;
      end else if (b_tgt == dmd_pkg::TGT_EXT) begin
        ext_bus.req   <= 1'b1;
        ext_bus.prog  <= 1'b0;
        ext_bus.write <= b_req.write;
        ext_bus.addr  <= {7'h00, b_req.addr};
        ext_bus.wdata <= b_req.wdata;
      end
    end
  end

  // Answers, one cycle after the access stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_rsp <= '0;
    end else begin
      a_rsp.valid  <= (a_tgt_q != dmd_pkg::TGT_NONE);
      a_rsp.ext    <= (a_tgt_q == dmd_pkg::TGT_EXT);
      a_rsp.denied <= (a_tgt_q == dmd_pkg::TGT_DENY);
      case (a_tgt_q)
        dmd_pkg::TGT_RAM: a_rsp.data <= a_word[a_blk_q];
        dmd_pkg::TGT_ROM: a_rsp.data <= rom_rdata;
        dmd_pkg::TGT_MMR: a_rsp.data <= a_mmr_q;
        default:          a_rsp.data <= 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      b_rsp <= '0;
    end else begin
      b_rsp.valid  <= (b_tgt_q != dmd_pkg::TGT_NONE);
      b_rsp.ext    <= (b_tgt_q == dmd_pkg::TGT_EXT);
      b_rsp.denied <= (b_tgt_q == dmd_pkg::TGT_DENY);
      case (b_tgt_q)
        dmd_pkg::TGT_RAM: b_rsp.data <= b_word[b_blk_q];
        dmd_pkg::TGT_MMR: b_rsp.data <= b_mmr_q;
        default:          b_rsp.data <= 16'h0000;
      endcase
    end
  end

  // Program counter load: reset vector once, then interrupt or trap vectors
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_load.valid <= 1'b0;
      pc_load.addr  <= `DMD_VECT_LO;
    end else if (init_q) begin
      pc_load.valid <= 1'b1;
      pc_load.addr  <= {vptr_q, 7'h00};
    end else begin
      pc_load.valid <= vec_req;
      if (vec_req) begin
        pc_load.addr <= {vptr_q, vec_num, 2'b00};
      end
    end
  end

endmodule
